// ### logic/tspc_pkg.sv
// package: phase timing, controls and carriers for the two-stage pipeline control
package tspc_pkg;
  // ************************************************
  // widths
  // ************************************************
  localparam int ADDR_W = 32;
  localparam int INSN_W = 16;
  localparam int REG_W  = 4;
  localparam int IL_W   = 2;

  // ************************************************
  // instruction field positions
  // ************************************************
  localparam int DST_LSB  = 4;
  localparam int SRC_LSB  = 0;
  localparam int IL_LSB   = 8;
  localparam int XP_BIT   = 10;
  localparam int DSP_BIT  = 11;
  localparam int IMM_BIT  = 12;

  // ************************************************
  // reset values and counts
  // ************************************************
  localparam logic [ADDR_W-1:0] PC_RESET   = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] PC_STEP    = 32'h0000_0002;
  localparam int                NUM_STAGES = 2;
  localparam int                ALU_PHASES = 5;
  localparam logic [1:0]        DSP_BUSY_CYCLES = 2'h1;

  // ************************************************
  // phase within a stage cycle
  // ************************************************
  typedef enum logic {
    TSPC_LOW_CLOCK_PHASE  = 1'b0,
    TSPC_HIGH_CLOCK_PHASE = 1'b1
  } tspc_phase_e;

  // ************************************************
  // decoded controls carried from fetch/decode to execute
  // ************************************************
  typedef struct packed {
    logic              valid;
    logic [REG_W-1:0]  dst_sel;
    logic [REG_W-1:0]  src_sel;
    logic [IL_W-1:0]   il_code;
    logic              imm_latch;
    logic              extra_phase;
    logic              dsp;
  } tspc_dec_s;
endpackage

// ### logic/tspc_dsp_lock.sv
// module: dsp resource interlock counter
`timescale 1ns/1ns
module tspc_dsp_lock (
  // clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  // request
  input  wire logic start_in,
  input  wire logic next_dsp_in,
  // state
  output logic      stall_out
);
  logic [1:0] busy_r;

  // ************************************************
  // busy counter
  // ************************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      busy_r <= 2'h0;
    end else if (ce_in) begin
      if (start_in && busy_r == 2'h0) begin
        busy_r <= tspc_pkg::DSP_BUSY_CYCLES;
      end else if (busy_r != 2'h0) begin
        busy_r <= busy_r - 2'h1;
      end
    end
  end

  assign stall_out = (busy_r != 2'h0) && next_dsp_in;
endmodule

// ### logic/tspc_ctrl.sv
// module: two-stage pipeline control, phase sequencer and datapath controls
//
// Summary of operation
// - two stages, each low then high phase
// - alu instruction spans four phases, five with extra phase
// - extra alu phase never stalls next instruction
// - back-to-back dsp instructions wait for resource
// - fetch low phase reads icache at pc
// - decode high phase drives operand selects
// - decode high drives immediate latch, length
// - decode high computes next pc
// - execute low phase fetches next instruction
// - execute low resolves registers and immediate
// - execute low reads register stack
// - execute low drives x, y latches, q latch for dsp only
// - execute high runs alu operation
// - execute high writes result back
// - extra phase writes result next low
`timescale 1ns/1ns
module tspc_ctrl (
  // clock and reset
  input  wire logic                         core_clk_in,
  input  wire logic                         rst_in,
  input  wire logic                         ce_in,
  // instruction cache
  input  wire logic [tspc_pkg::INSN_W-1:0]  icache_data_in,
  output logic                              icache_rd_out,
  output logic [tspc_pkg::ADDR_W-1:0]       icache_addr_out,
  // decode controls
  output logic                              low_clock_phase_out,
  output logic                              high_clock_phase_out,
  output logic [tspc_pkg::REG_W-1:0]        dest_operand_select_out,
  output logic [tspc_pkg::REG_W-1:0]        source_operand_select_out,
  output logic                              immediate_operand_latch_out,
  output logic [tspc_pkg::IL_W-1:0]         instruction_length_code_out,
  output logic [tspc_pkg::ADDR_W-1:0]       pc_out,
  // register stack
  output logic                              rf_rd_out,
  output logic [tspc_pkg::REG_W-1:0]        rf_src_addr_out,
  output logic [tspc_pkg::REG_W-1:0]        rf_dst_addr_out,
  output logic                              imm_sel_out,
  output logic                              aux_x_operand_latch_out,
  output logic                              aux_y_operand_latch_out,
  output logic                              aux_q_operand_latch_out,
  // alu and write back
  output logic                              alu_exec_out,
  output logic                              rf_wr_out,
  output logic [tspc_pkg::REG_W-1:0]        rf_wr_addr_out,
  output logic                              extra_wr_out,
  output logic                              dsp_stall_out
);
  tspc_pkg::tspc_phase_e            phase_r;
  logic [tspc_pkg::ADDR_W-1:0]      pc_r;
  logic [tspc_pkg::INSN_W-1:0]      insn_r;
  logic                             insn_vld_r;
  tspc_pkg::tspc_dec_s              ex_r;
  tspc_pkg::tspc_dec_s              dec_nxt;
  logic [tspc_pkg::ADDR_W-1:0]      pc_nxt;
  logic                             ext_pend_r;
  logic [tspc_pkg::REG_W-1:0]       ext_addr_r;
  logic                             stall;
  logic                             low;
  logic                             high;
  logic                             hold_r;

  // ************************************************
  // decode function
  // ************************************************
  function automatic tspc_pkg::tspc_dec_s decode(input logic [tspc_pkg::INSN_W-1:0] i, input logic v);
    tspc_pkg::tspc_dec_s d;
    d.valid       = v;
    d.dst_sel     = i[tspc_pkg::DST_LSB +: tspc_pkg::REG_W];
    d.src_sel     = i[tspc_pkg::SRC_LSB +: tspc_pkg::REG_W];
    d.il_code     = i[tspc_pkg::IL_LSB +: tspc_pkg::IL_W];
    d.imm_latch   = i[tspc_pkg::IMM_BIT];
    d.extra_phase = i[tspc_pkg::XP_BIT];
    d.dsp         = i[tspc_pkg::DSP_BIT];
    return d;
  endfunction

  assign low     = (phase_r == tspc_pkg::TSPC_LOW_CLOCK_PHASE);
  assign high    = (phase_r == tspc_pkg::TSPC_HIGH_CLOCK_PHASE);
  assign dec_nxt = decode(insn_r, insn_vld_r);
  assign pc_nxt  = dec_nxt.valid ? pc_r + tspc_pkg::PC_STEP + {29'h0, dec_nxt.il_code, 1'b0}
                                 : pc_r;

  // ************************************************
  // dsp interlock
  // ************************************************
  tspc_dsp_lock u_lock (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .ce_in       (ce_in && high),
    .start_in    (dec_nxt.valid && dec_nxt.dsp),
    .next_dsp_in (dec_nxt.valid && dec_nxt.dsp),
    .stall_out   (stall)
  );

  // ************************************************
  // phase sequencer
  // ************************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      phase_r <= tspc_pkg::TSPC_LOW_CLOCK_PHASE;
    end else if (ce_in) begin
      phase_r <= high ? tspc_pkg::TSPC_LOW_CLOCK_PHASE : tspc_pkg::TSPC_HIGH_CLOCK_PHASE;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      low_clock_phase_out  <= 1'b1;
      high_clock_phase_out <= 1'b0;
      hold_r               <= 1'b0;
    end else if (ce_in) begin
      low_clock_phase_out  <= high;
      high_clock_phase_out <= low;
      hold_r               <= stall;
    end
  end

  // ************************************************
  // fetch: icache read in every low phase except the first after reset and the one after a dsp interlock stall
  // ************************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      icache_rd_out   <= 1'b0;
      icache_addr_out <= tspc_pkg::PC_RESET;
      insn_r          <= 16'h0000;
      insn_vld_r      <= 1'b0;
    end else if (ce_in) begin
      icache_rd_out   <= high && !stall;
      if (high && !stall) begin
        icache_addr_out <= pc_nxt;
      end
      if (low && icache_rd_out) begin
        insn_r     <= icache_data_in;
        insn_vld_r <= 1'b1;
      end
    end
  end

  // ************************************************
  // decode high phase: selects, immediate, length, pc
  // ************************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pc_r                        <= tspc_pkg::PC_RESET;
      dest_operand_select_out     <= 4'h0;
      source_operand_select_out   <= 4'h0;
      immediate_operand_latch_out <= 1'b0;
      instruction_length_code_out <= 2'h0;
      ex_r                        <= '0;
    end else if (ce_in) begin
      immediate_operand_latch_out <= 1'b0;
      if (high) begin
        if (stall) begin
          ex_r <= '0;
        end else begin
          dest_operand_select_out     <= dec_nxt.dst_sel;
          source_operand_select_out   <= dec_nxt.src_sel;
          immediate_operand_latch_out <= dec_nxt.valid && dec_nxt.imm_latch;
          instruction_length_code_out <= dec_nxt.il_code;
          pc_r <= pc_nxt;
          ex_r <= dec_nxt;
        end
      end
    end
  end

  assign pc_out        = pc_r;
  assign dsp_stall_out = hold_r;

  // ************************************************
  // execute low: register read, aux latches
  // ************************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rf_rd_out               <= 1'b0;
      rf_src_addr_out         <= 4'h0;
      rf_dst_addr_out         <= 4'h0;
      imm_sel_out             <= 1'b0;
      aux_x_operand_latch_out <= 1'b0;
      aux_y_operand_latch_out <= 1'b0;
      aux_q_operand_latch_out <= 1'b0;
    end else if (ce_in) begin
      rf_rd_out               <= high && !stall && dec_nxt.valid;
      imm_sel_out             <= high && !stall && dec_nxt.valid && dec_nxt.imm_latch;
      aux_x_operand_latch_out <= high && !stall && dec_nxt.valid;
      aux_y_operand_latch_out <= high && !stall && dec_nxt.valid;
      aux_q_operand_latch_out <= high && !stall && dec_nxt.valid && dec_nxt.dsp;
      if (high && !stall) begin
        rf_src_addr_out <= dec_nxt.src_sel;
        rf_dst_addr_out <= dec_nxt.dst_sel;
      end
    end
  end

  // ************************************************
  // execute high: alu and write back, extra phase
  // ************************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      alu_exec_out   <= 1'b0;
      rf_wr_out      <= 1'b0;
      rf_wr_addr_out <= 4'h0;
      extra_wr_out   <= 1'b0;
      ext_pend_r     <= 1'b0;
      ext_addr_r     <= 4'h0;
    end else if (ce_in) begin
      alu_exec_out <= low && rf_rd_out;
      rf_wr_out    <= 1'b0;
      extra_wr_out <= 1'b0;
      if (low && rf_rd_out && !ex_r.extra_phase) begin
        rf_wr_out      <= 1'b1;
        rf_wr_addr_out <= rf_dst_addr_out;
      end
      if (low && rf_rd_out && ex_r.extra_phase) begin
        ext_pend_r <= 1'b1;
        ext_addr_r <= rf_dst_addr_out;
      end
      if (high && ext_pend_r) begin
        extra_wr_out   <= 1'b1;
        rf_wr_out      <= 1'b1;
        rf_wr_addr_out <= ext_addr_r;
        ext_pend_r     <= 1'b0;
      end
    end
  end

  // ************************************************
  // checks
  // ************************************************
  chk_phase_alternate: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ce_in |=> phase_r != $past(phase_r)) else $error("phase did not alternate");
  chk_fetch_low: assert property (@(posedge core_clk_in) disable iff (rst_in)
    icache_rd_out |-> low) else $error("fetch outside low phase");
  chk_stall_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (ce_in && high && stall) |=> pc_r == $past(pc_r)) else $error("pc moved during stall");
  chk_stall_nop: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (ce_in && high && stall) |=> !ex_r.valid) else $error("no nop inserted");
  chk_rf_read_low: assert property (@(posedge core_clk_in) disable iff (rst_in)
    rf_rd_out |-> low) else $error("register read outside low phase");
  chk_alu_high: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (ce_in && low && rf_rd_out) |=> alu_exec_out && high) else $error("alu not run in high phase");
  chk_extra_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (ce_in && low && rf_rd_out && ex_r.extra_phase) ##1 ce_in |=> extra_wr_out && low)
    else $error("extra phase write missing");
  chk_extra_nostall: assert property (@(posedge core_clk_in) disable iff (rst_in)
    extra_wr_out |-> rf_rd_out || hold_r) else $error("extra phase stalled pipeline");
  chk_alu_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (ce_in && low && rf_rd_out && !ex_r.extra_phase) |=> rf_wr_out && high)
    else $error("alu result not written in high phase");
  chk_extra_pending: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (ce_in && low && rf_rd_out && ex_r.extra_phase) |=> ext_pend_r && !rf_wr_out)
    else $error("extra phase instruction wrote too early");
  chk_exec_overlap: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (ce_in && high && !stall && dec_nxt.valid) |=> rf_rd_out && icache_rd_out)
    else $error("execute low did not overlap next fetch");
  chk_pc_even: assert property (@(posedge core_clk_in) disable iff (rst_in)
    pc_r[0] == 1'b0)
    else $error("pc not halfword aligned");
  chk_aux_q_read: assert property (@(posedge core_clk_in) disable iff (rst_in)
    aux_q_operand_latch_out |-> aux_x_operand_latch_out && rf_rd_out)
    else $error("q latch without operand read");
  chk_imm_latch: assert property (@(posedge core_clk_in) disable iff (rst_in)
    immediate_operand_latch_out |-> rf_rd_out && low)
    else $error("immediate latch outside decoded slot");
  chk_dsp_gap: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (ce_in && high && !stall && dec_nxt.valid && dec_nxt.dsp) ##1 ce_in
    ##1 (ce_in && high && dec_nxt.valid && dec_nxt.dsp) |-> stall)
    else $error("back to back dsp not interlocked");
  chk_phase_onehot: assert property (@(posedge core_clk_in) disable iff (rst_in)
    low_clock_phase_out != high_clock_phase_out)
    else $error("phase outputs not one-hot");
  chk_stall_nofetch: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (ce_in && high && stall) |=> !icache_rd_out)
    else $error("fetch during interlock");
  chk_stall_flag: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (ce_in && high && stall) |=> dsp_stall_out)
    else $error("interlock not flagged");
endmodule

// ### testbench/tspc_icache_model.sv
// instruction cache model answering fetches of the pipeline control
`timescale 1ns/1ns
module tspc_icache_model (
  // fetch request
  input  wire logic                        rd_in,
  input  wire logic [tspc_pkg::ADDR_W-1:0] addr_in,
  // fetched word
  output logic [tspc_pkg::INSN_W-1:0]      data_out
);
  logic [tspc_pkg::INSN_W-1:0] mem [0:127];
  logic [tspc_pkg::INSN_W-1:0] last_r;

  initial last_r = 16'h0000;

  // remember the last word handed out
  always @(rd_in, addr_in) begin
    if (rd_in) begin
      last_r = mem[addr_in[7:1]];
    end
  end

  // word at the fetch address, scrambled while idle
  assign data_out = rd_in ? mem[addr_in[7:1]] : ~last_r;
endmodule

// ### testbench/two_stage_pipeline_control_bench.sv
// self-checking bench for the two-stage pipeline control
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module two_stage_pipeline_control_bench;
  // ************************************************
  // signals
  // ************************************************
  logic        core_clk_in = 1'b0;
  logic        rst_in      = 1'b1;
  logic        ce_in       = 1'b0;
  logic [15:0] icache_data;
  logic        icache_rd;
  logic [31:0] icache_addr;
  logic        low;
  logic        high;
  logic [31:0] pc;
  logic        rf_wr;
  logic [3:0]  rf_wr_addr;
  logic        extra_wr;
  logic        dsp_stall;
  logic        alu_exec;
  logic        rf_rd;
  logic        imm_lat;
  logic        imm_sel;
  logic        aux_x;
  logic        aux_y;
  logic        aux_q;
  logic [1:0]  il_code;
  logic [3:0]  dsel;
  logic [3:0]  ssel;
  logic [3:0]  rf_dst;
  logic [3:0]  rf_src;
  logic [22:0] dq [$];
  int          n_fail      = 0;
  int          comparisons = 0;
  logic [31:0] fa [$];
  int          ft [$];
  logic [3:0]  wa [$];
  int          n_extra, n_stall, n_alu, cyc;

  always #5 core_clk_in = ~core_clk_in;

  tspc_ctrl dut (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .icache_data_in(icache_data), .icache_rd_out(icache_rd), .icache_addr_out(icache_addr),
    .low_clock_phase_out(low), .high_clock_phase_out(high),
    .dest_operand_select_out(dsel), .source_operand_select_out(ssel),
    .immediate_operand_latch_out(imm_lat), .instruction_length_code_out(il_code), .pc_out(pc),
    .rf_rd_out(rf_rd), .rf_src_addr_out(rf_src), .rf_dst_addr_out(rf_dst), .imm_sel_out(imm_sel),
    .aux_x_operand_latch_out(aux_x), .aux_y_operand_latch_out(aux_y), .aux_q_operand_latch_out(aux_q),
    .alu_exec_out(alu_exec), .rf_wr_out(rf_wr), .rf_wr_addr_out(rf_wr_addr),
    .extra_wr_out(extra_wr), .dsp_stall_out(dsp_stall)
  );

  tspc_icache_model icm (
    .rd_in(icache_rd), .addr_in(icache_addr), .data_out(icache_data)
  );

  // ************************************************
  // monitor
  // ************************************************
  always @(posedge core_clk_in) begin
    cyc++;
    if (!rst_in && ce_in) begin
      if (icache_rd) begin
        fa.push_back(icache_addr);
        ft.push_back(cyc);
      end
      if (rf_wr) wa.push_back(rf_wr_addr);
      if (rf_rd) dq.push_back({imm_lat, imm_sel, aux_q, aux_x, aux_y, il_code, dsel, ssel, rf_dst, rf_src});
      if (extra_wr) n_extra++;
      if (dsp_stall) n_stall++;
      if (alu_exec) n_alu++;
    end
  end

  // ************************************************
  // helpers
  // ************************************************
  task automatic load(input logic [15:0] p [$]);
    for (int i = 0; i < 128; i++) icm.mem[i] = (i < p.size()) ? p[i] : 16'h0000;
  endtask

  task automatic run(input int n);
    @(negedge core_clk_in) rst_in = 1'b1;
    fa.delete(); ft.delete(); wa.delete(); dq.delete();
    n_extra = 0; n_stall = 0; n_alu = 0;
    @(negedge core_clk_in) rst_in = 1'b0;
    ce_in = 1'b1;
    repeat (n) @(negedge core_clk_in) `CHK(low ^ high, 1'b1)
  endtask

  task automatic chk_fetch(input int n);
    logic [31:0] a;
    a = 32'h0000_0000;
    for (int i = 0; i < n; i++) begin
      `CHK(fa[i], a)
      a = a + tspc_pkg::PC_STEP + {29'h0, icm.mem[a[7:1]][9:8], 1'b0};
    end
  endtask

  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_alu();
    logic [15:0] w [4];
    w = '{16'h1021, 16'h0143, 16'h1265, 16'h0087};
    load('{16'h1021, 16'h0143, 16'hFFFF, 16'h1265, 16'hFFFF, 16'hFFFF, 16'h0087});
    run(30);
    chk_fetch(8);
    for (int i = 0; i < 4; i++) begin
      `CHK(wa[i], 4'(2 * i + 2))
      `CHK(dq[i][22:21], {2{w[i][12]}})
      `CHK(dq[i][20:18], {w[i][11], 2'b11})
      `CHK(dq[i][17:8], w[i][9:0])
      `CHK(dq[i][7:0], w[i][7:0])
    end
    `CHK(n_alu >= 4, 1'b1)
  endtask

  task automatic t_extra();
    load('{16'h0412, 16'h0434, 16'h0456, 16'h0478});
    run(30);
    `CHK(n_extra, 4)
    for (int i = 0; i < 4; i++) `CHK(ft[i + 1] - ft[i], 2)
    `CHK(n_stall, 0)
  endtask

  task automatic t_dsp();
    load('{16'h0812, 16'h0834, 16'h0056});
    run(30);
    `CHK(n_stall > 0, 1'b1)
    `CHK(ft[3] - ft[0] > 6, 1'b1)
    chk_fetch(5);
  endtask

  task automatic t_hold();
    logic [31:0] p;
    logic [33:0] s;
    int          k;
    load('{16'h0112, 16'h0234});
    run(10);
    @(negedge core_clk_in) ce_in = 1'b0;
    p = pc;
    s = {icache_rd, low, icache_addr};
    k = fa.size();
    repeat (6) @(negedge core_clk_in) begin
      `CHK(pc, p)
      `CHK({icache_rd, low, icache_addr}, s)
    end
    `CHK(fa.size(), k)
    ce_in = 1'b1;
    repeat (4) @(negedge core_clk_in);
    `CHK(fa.size() > k, 1'b1)
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge core_clk_in);
    rst_in = 1'b0;
    t_alu();
    t_extra();
    t_dsp();
    t_hold();
    results();
  end

  initial begin
    #50000;
    n_fail++;
    results();
  end
endmodule
